// File: rtl/fbr_consts.vh
// constants shared by the frame buffer reader files
`ifndef FBR_CONSTS_VH
`define FBR_CONSTS_VH

// ----------------------------------------------------------------
// register byte offsets on the control slave
// ----------------------------------------------------------------
`define FBR_OFF_FRONT    4'h0
`define FBR_OFF_STANDBY  4'h4
`define FBR_OFF_DIMS     4'h8
`define FBR_OFF_STATE    4'hc

// ----------------------------------------------------------------
// field positions of frame_dimensions
// ----------------------------------------------------------------
`define FBR_DIM_X_LO     0
`define FBR_DIM_X_HI     15
`define FBR_DIM_Y_LO     16
`define FBR_DIM_Y_HI     31

// ----------------------------------------------------------------
// field positions of reader_state
// ----------------------------------------------------------------
`define FBR_ST_SWAP      0
`define FBR_ST_MODE      1
`define FBR_ST_BPP_LO    4
`define FBR_ST_BPP_HI    7
`define FBR_ST_XW_LO     16
`define FBR_ST_XW_HI     23
`define FBR_ST_YW_LO     24
`define FBR_ST_YW_HI     31

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define FBR_RST_WORD     32'h0000_0000
`define FBR_RST_BIT      1'b0

// addressing mode codes in the state word
`define FBR_MODE_XY      1'b0
`define FBR_MODE_CONSEC  1'b1

`endif

// File: rtl/fbr_addr_gen.v
// pixel address generator of the frame buffer reader
module fbr_addr_gen #(
    parameter BPP      = 2,   // bytes per pixel
    parameter X_BITS   = 10,  // horizontal coordinate width
    parameter Y_BITS   = 9,   // vertical coordinate width
    parameter PIX_BITS = 19   // linear pixel index width
) (
    input  wire [31:0]         base,
    input  wire [X_BITS-1:0]   x_idx,
    input  wire [Y_BITS-1:0]   y_idx,
    input  wire [PIX_BITS-1:0] lin_idx,
    input  wire                mode_consec,
    output wire [31:0]         pix_addr
);

    // ----------------------------------------------------------------
    // index forming
    // ----------------------------------------------------------------
    localparam [31:0] BPP_W = BPP;          // byte step per pixel

    wire [31:0] xy_index;                   // line index above x field
    wire [31:0] lin_index;                  // running pixel count
    wire [31:0] pix_index;                  // selected pixel index
    wire [31:0] byte_off;                   // index scaled to bytes

    // x-y form puts the line number just above the x coordinate
    assign xy_index  = {{(32-X_BITS-Y_BITS){1'b0}}, y_idx, x_idx};  // see (RQ17)
    assign lin_index = {{(32-PIX_BITS){1'b0}}, lin_idx};
    assign pix_index = mode_consec ? lin_index : xy_index;        // see (RQ2)

    // ----------------------------------------------------------------
    // byte scaling
    // ----------------------------------------------------------------
    // both modes step by the byte length of one pixel
    assign byte_off  = pix_index * BPP_W;                          // see (RQ2)
    assign pix_addr  = base + byte_off;                            // see (RQ17)

endmodule // fbr_addr_gen

// File: rtl/fbr_reader.v
// frame buffer reader: fetches frames from memory and streams pixels
//
// Overview of operation
// (RQ1) fetch frame pixels, stream them out
// (RQ2) consecutive or x-y addressing, scaled by bytes
// (RQ3) front register shows current frame start
// (RQ4) standby register at 4 is read/write
// (RQ5) front write only requests swap, data ignored
// (RQ6) swap happens at the frame's last pixel
// (RQ7) state bit 0 shows swap pending
// (RQ8) dimensions at 8: width low, height high
// (RQ9) state bits 31-24: y coordinate width
// (RQ10) state bits 23-16: x coordinate width
// (RQ11) state bits 7-4: bytes per pixel
// (RQ12) state bit 1: 0 x-y, 1 consecutive
// (RQ13) software writes zero to reserved bits
// (RQ14) reset loads default buffer addresses
// (RQ15) size and colour format fixed at build
// (RQ16) software sets standby first, then front
// (RQ17) x-y address: line above x field, scaled
// (RQ18) first pixel sop, last eop, honour ready
`include "fbr_consts.vh"

module fbr_reader #(
    parameter        WIDTH         = 640,          // pixels per line
    parameter        HEIGHT        = 480,          // lines per frame
    parameter        BPP           = 2,            // bytes per pixel
    parameter        ADDR_CONSEC   = 1,            // 1 consecutive, 0 x-y
    parameter [31:0] FRONT_DEFAULT = 32'h0000_0000, // front start at reset
    parameter [31:0] BACK_DEFAULT  = 32'h0000_0000  // standby start at reset
) (
    input  wire             clk,
    input  wire             rst,
    // control slave
    input  wire [3:0]       avs_address,
    input  wire             avs_chipselect,
    input  wire             avs_read,
    input  wire             avs_write,
    input  wire [3:0]       avs_byteenable,
    input  wire [31:0]      avs_writedata,
    output reg  [31:0]      avs_readdata,
    // memory master
    output reg  [31:0]      avm_address,
    output reg              avm_read,
    input  wire [BPP*8-1:0] avm_readdata,
    input  wire             avm_readdatavalid,
    input  wire             avm_waitrequest,
    // pixel stream source
    output reg  [BPP*8-1:0] st_data,
    output reg              st_startofpacket,
    output reg              st_endofpacket,
    output reg              st_valid,
    input  wire             st_ready
);

    // ----------------
    // build-time geometry
    // ----------------
    // frame size and pixel format are fixed here, see (RQ15)
    localparam X_BITS   = $clog2(WIDTH);          // x coordinate width
    localparam Y_BITS   = $clog2(HEIGHT);         // y coordinate width
    localparam PIX_BITS = $clog2(WIDTH * HEIGHT); // linear index width

    localparam [31:0] WIDTH_W  = WIDTH;           // width as a word
    localparam [31:0] HEIGHT_W = HEIGHT;          // height as a word
    localparam [31:0] X_LAST   = WIDTH - 1;       // last x coordinate
    localparam [31:0] Y_LAST   = HEIGHT - 1;      // last line
    localparam [31:0] XW_W     = X_BITS;          // x width for state word
    localparam [31:0] YW_W     = Y_BITS;          // y width for state word
    localparam [31:0] BPP_W    = BPP;             // bytes per pixel word
    localparam        MODE_BIT = (ADDR_CONSEC != 0) ? `FBR_MODE_CONSEC : `FBR_MODE_XY;

    // ----------------
    // fetch states, one-hot
    // ----------------
    localparam [3:0] ST_ADDR  = 4'h1;  // load the next pixel address
    localparam [3:0] ST_FETCH = 4'h2;  // hold read until accepted
    localparam [3:0] ST_WAIT  = 4'h4;  // wait for the read data
    localparam [3:0] ST_SEND  = 4'h8;  // offer the pixel downstream

    // ----------------
    // declarations
    // ----------------
    reg  [3:0]          state_reg;      // fetch state
    reg  [3:0]          state_next;     // next fetch state
    reg  [31:0]         front_reg;      // start of frame on screen
    reg  [31:0]         back_reg;       // start of standby frame
    reg                 swap_pend_reg;  // exchange requested
    reg  [X_BITS-1:0]   x_reg;          // pixel within line
    reg  [Y_BITS-1:0]   y_reg;          // line within frame
    reg  [PIX_BITS-1:0] lin_reg;        // pixel within frame
    wire [31:0]         pix_addr;       // address of current pixel
    wire                sel_front;      // access to front register
    wire                sel_back;       // access to standby register
    wire                sel_dims;       // access to dimensions
    wire                sel_state;      // access to state word
    wire                wr_front;       // swap request strobe
    wire                wr_back;        // standby write strobe
    wire                rd_cyc;         // register read strobe
    wire                line_end;       // current pixel ends a line
    wire                frame_end;      // current pixel ends the frame
    wire                px_taken;       // pixel accepted downstream
    wire                swap_now;       // exchange performed this cycle
    wire [31:0]         dims_word;      // dimensions read value
    wire [31:0]         state_word;     // state read value
    wire [31:0]         back_wr_val;    // standby value after byte lanes
    reg  [31:0]         rd_mux;         // selected read value

    // ----------------
    // register decode
    // ----------------
    // word match on the byte address, low two bits ignored
    function hit;
        input [3:0] addr;
        input [3:0] off;
        begin
            hit = (addr[3:2] == off[3:2]);
        end
    endfunction

    assign sel_front = avs_chipselect & hit(avs_address, `FBR_OFF_FRONT);
    assign sel_back  = avs_chipselect & hit(avs_address, `FBR_OFF_STANDBY);
    assign sel_dims  = avs_chipselect & hit(avs_address, `FBR_OFF_DIMS);
    assign sel_state = avs_chipselect & hit(avs_address, `FBR_OFF_STATE);

    // any front write is a swap request whatever the data
    assign wr_front  = sel_front & avs_write;       // see (RQ5)
    assign wr_back   = sel_back & avs_write;        // see (RQ4)
    assign rd_cyc    = avs_chipselect & avs_read;

    // ----------------
    // frame position
    // ----------------
    assign line_end  = (x_reg == X_LAST[X_BITS-1:0]);
    assign frame_end = line_end & (y_reg == Y_LAST[Y_BITS-1:0]);
    assign px_taken  = (state_reg == ST_SEND) & st_ready;     // see (RQ18)
    // exchange only once the last pixel of the frame has gone out
    assign swap_now  = px_taken & frame_end & swap_pend_reg;  // see (RQ6)

    // ----------------
    // standby byte lanes
    // ----------------
    // each enabled lane takes the written byte, others keep theirs
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
            assign back_wr_val[lane*8 +: 8] = avs_byteenable[lane] ?
                avs_writedata[lane*8 +: 8] : back_reg[lane*8 +: 8];
        end
    endgenerate

    // ----------------
    // buffer address registers
    // ----------------
    // front is never loaded from the bus, only by the exchange
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            front_reg <= FRONT_DEFAULT;             // see (RQ14)
            back_reg  <= BACK_DEFAULT;              // see (RQ14)
        end else begin
            if (swap_now) begin
                front_reg <= back_reg;              // see (RQ6)
            end
            if (wr_back) begin
                // a software write in the swap cycle wins the standby slot
                back_reg <= back_wr_val;            // see (RQ4)
            end else if (swap_now) begin
                back_reg <= front_reg;              // see (RQ6)
            end
        end
    end

    // ----------------
    // swap pending flag
    // ----------------
    // a request arriving in the swap cycle stays pending for next frame
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            swap_pend_reg <= `FBR_RST_BIT;
        end else if (wr_front) begin
            swap_pend_reg <= 1'b1;                  // see (RQ7)
        end else if (swap_now) begin
            swap_pend_reg <= 1'b0;                  // see (RQ7)
        end
    end

    // ----------------
    // read values
    // ----------------
    // width in the low half, height in the high half
    assign dims_word[`FBR_DIM_X_HI:`FBR_DIM_X_LO] = WIDTH_W[15:0];   // see (RQ8)
    assign dims_word[`FBR_DIM_Y_HI:`FBR_DIM_Y_LO] = HEIGHT_W[15:0];  // see (RQ8)

    // reserved bits of the state word read as zero
    assign state_word[`FBR_ST_YW_HI:`FBR_ST_YW_LO]   = YW_W[7:0];    // see (RQ9)
    assign state_word[`FBR_ST_XW_HI:`FBR_ST_XW_LO]   = XW_W[7:0];    // see (RQ10)
    assign state_word[`FBR_ST_XW_LO-1:`FBR_ST_BPP_HI+1] = 8'h00;
    assign state_word[`FBR_ST_BPP_HI:`FBR_ST_BPP_LO] = BPP_W[3:0];   // see (RQ11)
    assign state_word[`FBR_ST_BPP_LO-1:`FBR_ST_MODE+1] = 2'h0;
    assign state_word[`FBR_ST_MODE]                  = MODE_BIT;     // see (RQ12)
    assign state_word[`FBR_ST_SWAP]                  = swap_pend_reg; // see (RQ7)

    // read selection
    always @* begin
        rd_mux = `FBR_RST_WORD;
        case (1'b1)
            sel_front: rd_mux = front_reg;          // see (RQ3)
            sel_back:  rd_mux = back_reg;           // see (RQ4)
            sel_dims:  rd_mux = dims_word;          // see (RQ8)
            sel_state: rd_mux = state_word;
            default:   rd_mux = `FBR_RST_WORD;
        endcase
    end

    // read data one cycle after the read strobe
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            avs_readdata <= `FBR_RST_WORD;
        end else if (rd_cyc) begin
            avs_readdata <= rd_mux;
        end
    end

    // ----------------
    // pixel address
    // ----------------
    fbr_addr_gen #(
        .BPP      (BPP),
        .X_BITS   (X_BITS),
        .Y_BITS   (Y_BITS),
        .PIX_BITS (PIX_BITS)
    ) u_addr_gen (
        .base        (front_reg),
        .x_idx       (x_reg),
        .y_idx       (y_reg),
        .lin_idx     (lin_reg),
        .mode_consec (MODE_BIT),
        .pix_addr    (pix_addr)
    );

    // ----------------
    // fetch state machine
    // ----------------
    // one read in flight at a time, one pixel held for the stream
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_ADDR: begin
                state_next = ST_FETCH;
            end
            ST_FETCH: begin
                // read stays up until the memory accepts it
                if (!avm_waitrequest) begin
                    state_next = ST_WAIT;           // see (RQ1)
                end
            end
            ST_WAIT: begin
                if (avm_readdatavalid) begin
                    state_next = ST_SEND;           // see (RQ1)
                end
            end
            ST_SEND: begin
                // stall here while downstream is not ready
                if (st_ready) begin
                    state_next = ST_ADDR;           // see (RQ18)
                end
            end
            default: begin
                state_next = ST_ADDR;
            end
        endcase
    end

    // state register
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_ADDR;
        end else begin
            state_reg <= state_next;
        end
    end

    // ----------------
    // memory master outputs
    // ----------------
    // address is captured once per pixel and held over the read
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            avm_address <= `FBR_RST_WORD;
            avm_read    <= `FBR_RST_BIT;
        end else begin
            case (state_reg)
                ST_ADDR: begin
                    avm_address <= pix_addr;        // see (RQ2)
                    avm_read    <= 1'b1;            // see (RQ1)
                end
                ST_FETCH: begin
                    if (!avm_waitrequest) begin
                        avm_read <= 1'b0;
                    end
                end
                default: begin
                    avm_read <= 1'b0;
                end
            endcase
        end
    end

    // ----------------
    // pixel position counters
    // ----------------
    // advance only when the stream has taken the pixel
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            x_reg   <= {X_BITS{1'b0}};
            y_reg   <= {Y_BITS{1'b0}};
            lin_reg <= {PIX_BITS{1'b0}};
        end else if (px_taken) begin
            if (frame_end) begin
                // wrap to the first pixel of the next frame
                x_reg   <= {X_BITS{1'b0}};
                y_reg   <= {Y_BITS{1'b0}};
                lin_reg <= {PIX_BITS{1'b0}};
            end else if (line_end) begin
                x_reg   <= {X_BITS{1'b0}};
                y_reg   <= y_reg + 1'b1;            // see (RQ17)
                lin_reg <= lin_reg + 1'b1;          // see (RQ2)
            end else begin
                x_reg   <= x_reg + 1'b1;
                lin_reg <= lin_reg + 1'b1;          // see (RQ2)
            end
        end
    end

    // ----------------
    // stream source outputs
    // ----------------
    // pixel and its frame marks are held until ready is seen
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            st_data          <= {(BPP*8){1'b0}};
            st_startofpacket <= `FBR_RST_BIT;
            st_endofpacket   <= `FBR_RST_BIT;
            st_valid         <= `FBR_RST_BIT;
        end else begin
            if ((state_reg == ST_WAIT) && avm_readdatavalid) begin
                st_data          <= avm_readdata;                    // see (RQ1)
                st_startofpacket <= (x_reg == {X_BITS{1'b0}}) &
                                    (y_reg == {Y_BITS{1'b0}});       // see (RQ18)
                st_endofpacket   <= frame_end;                       // see (RQ18)
                st_valid         <= 1'b1;
            end else if (px_taken) begin
                st_valid         <= 1'b0;                            // see (RQ18)
                st_startofpacket <= 1'b0;
                st_endofpacket   <= 1'b0;
            end
        end
    end

endmodule // fbr_reader

// File: bench/fbrd_mem_model.sv
// memory partner model: answers pixel reads with data derived from the address
module fbrd_mem_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [31:0] avm_address,
    input  wire logic        avm_read,
    output logic      [15:0] avm_readdata,
    output logic             avm_readdatavalid,
    output logic             avm_waitrequest,
    input  wire logic        slow
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] addr_reg;  // address of the accepted read
    int          wait_reg;  // cycles left before the answer, 0 when idle
    // ----------------
    // one read at a time, stalls and late answers when slow is set
    // ----------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            avm_readdata      <= 16'h0000;
            avm_readdatavalid <= 1'b0;
            avm_waitrequest   <= 1'b1;
            wait_reg          <= 0;
        end else begin
            avm_readdatavalid <= 1'b0;
            avm_readdata      <= ~avm_readdata;               // no stale data between answers
            avm_waitrequest   <= slow & ~avm_waitrequest;     // stall every other cycle when slow
            if (avm_read && !avm_waitrequest && wait_reg == 0) begin
                addr_reg <= avm_address;                      // accept the read
                wait_reg <= slow ? 4 : 1;
            end else if (wait_reg == 1) begin
                avm_readdatavalid <= 1'b1;
                avm_readdata      <= addr_reg[15:0] ^ 16'h5a5a;
                wait_reg          <= 0;
            end else if (wait_reg > 1) begin
                wait_reg <= wait_reg - 1;                     // still waiting
            end
        end
    end
endmodule // fbrd_mem_model

// File: bench/fbrd_chk.sv
// assertion checker on the ports of the frame buffer reader
module fbrd_chk #(
    parameter WIDTH       = 4,
    parameter HEIGHT      = 3,
    parameter BPP         = 2,
    parameter ADDR_CONSEC = 1
) (
    input wire logic             clk,
    input wire logic             rst,
    input wire logic [3:0]       avs_address,
    input wire logic             avs_chipselect,
    input wire logic             avs_read,
    input wire logic [31:0]      avs_readdata,
    input wire logic [31:0]      avm_address,
    input wire logic             avm_read,
    input wire logic [BPP*8-1:0] avm_readdata,
    input wire logic             avm_readdatavalid,
    input wire logic             avm_waitrequest,
    input wire logic [BPP*8-1:0] st_data,
    input wire logic             st_startofpacket,
    input wire logic             st_endofpacket,
    input wire logic             st_valid,
    input wire logic             st_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------
    // fixed register contents
    // ----------------
    localparam [31:0] DIMS   = (HEIGHT << 16) | WIDTH;
    localparam [31:0] ST_FIX = ($clog2(HEIGHT) << 24) | ($clog2(WIDTH) << 16) | (BPP << 4) | (ADDR_CONSEC << 1);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // ----------------
    // memory master, stream source and register reads
    // ----------------
    property p_read_hold; avm_read && avm_waitrequest |=> avm_read && $stable(avm_address); endproperty
    a_read_hold: assert property (p_read_hold) else $error("read dropped or moved while stalled");
    property p_one_read; avm_read && !avm_waitrequest |=> !avm_read; endproperty
    a_one_read: assert property (p_one_read) else $error("read held after acceptance");
    property p_pixel_src; $rose(st_valid) |-> $past(avm_readdatavalid) && st_data == $past(avm_readdata); endproperty
    a_pixel_src: assert property (p_pixel_src) else $error("pixel not taken from memory data");
    property p_stall_hold; st_valid && !st_ready |=> st_valid && $stable({st_data, st_startofpacket, st_endofpacket}); endproperty
    a_stall_hold: assert property (p_stall_hold) else $error("pixel changed under backpressure");
    property p_pixel_gap; st_valid && st_ready |=> !st_valid [*3]; endproperty
    a_pixel_gap: assert property (p_pixel_gap) else $error("pixel offered too soon");
    property p_refetch; st_valid && st_ready |-> ##[1:3] avm_read; endproperty
    a_refetch: assert property (p_refetch) else $error("no fetch after pixel accepted");
    property p_dims; avs_chipselect && avs_read && avs_address[3:2] == 2'b10 |=> avs_readdata == DIMS; endproperty
    a_dims: assert property (p_dims) else $error("dimension word wrong");
    property p_state_fix; avs_chipselect && avs_read && avs_address[3:2] == 2'b11 |=> avs_readdata[31:1] == ST_FIX[31:1]; endproperty
    a_state_fix: assert property (p_state_fix) else $error("state word fields wrong");
endmodule // fbrd_chk

bind fbr_reader fbrd_chk #(.WIDTH(WIDTH), .HEIGHT(HEIGHT), .BPP(BPP), .ADDR_CONSEC(ADDR_CONSEC)) chk (.clk, .rst,
    .avs_address, .avs_chipselect, .avs_read, .avs_readdata, .avm_address, .avm_read, .avm_readdata,
    .avm_readdatavalid, .avm_waitrequest, .st_data, .st_startofpacket, .st_endofpacket, .st_valid, .st_ready);

// File: bench/frame_buffer_reader_dma_test.sv
// self-checking bench for the frame buffer reader
module frame_buffer_reader_dma_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int    PIX  = 12;             // 4 x 3 pixels per frame
    localparam [31:0] FDEF = 32'h0000_1000;  // front start at reset
    localparam [31:0] BDEF = 32'h0000_2000;  // standby start at reset
    logic        clk = 1'b0, rst = 1'b1, avs_chipselect = 1'b0, avs_read = 1'b0, avs_write = 1'b0, st_ready = 1'b0;
    logic [3:0]  avs_address = 4'h0, avs_byteenable = 4'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, avm_address;
    logic        avm_read, avm_readdatavalid, avm_waitrequest, st_startofpacket, st_endofpacket, st_valid;
    logic [15:0] avm_readdata, st_data;
    logic        slow = 1'b1, go = 1'b0;     // partner slow when set; stream held off until go
    logic        pend_m = 1'b0;              // model of the swap request flag
    logic [31:0] front_m = FDEF, back_m = BDEF, seed = 32'd26712;
    int          bad_count = 0, checked = 0, pix = 0, frames = 0;
    fbr_reader #(.WIDTH(4), .HEIGHT(3), .BPP(2), .ADDR_CONSEC(1), .FRONT_DEFAULT(FDEF), .BACK_DEFAULT(BDEF)) uut (
        .clk, .rst, .avs_address, .avs_chipselect, .avs_read, .avs_write, .avs_byteenable, .avs_writedata,
        .avs_readdata, .avm_address, .avm_read, .avm_readdata, .avm_readdatavalid, .avm_waitrequest,
        .st_data, .st_startofpacket, .st_endofpacket, .st_valid, .st_ready);
    fbrd_mem_model mem (.clk, .rst, .avm_address, .avm_read, .avm_readdata, .avm_readdatavalid, .avm_waitrequest, .slow);
    // ----------------
    // clock, random backpressure and shared tasks
    // ----------------
    initial forever #25 clk = ~clk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    always @(posedge clk) begin
        seed = xs(seed);
        st_ready <= go & (seed[0] | seed[1]);  // ready three cycles in four
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge clk);
        avs_chipselect <= 1'b1;
        avs_write      <= 1'b1;
        avs_address    <= a;
        avs_writedata  <= d;
        avs_byteenable <= be;
        @(posedge clk);
        avs_chipselect <= 1'b0;
        avs_write      <= 1'b0;
        @(negedge clk);                      // let the model settle before the next expectation
    endtask
    task automatic reg_chk(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk);
        avs_chipselect <= 1'b1;
        avs_read       <= 1'b1;
        avs_address    <= a;
        @(posedge clk);
        avs_chipselect <= 1'b0;
        avs_read       <= 1'b0;
        @(negedge clk);
        check(avs_readdata, exp);
    endtask
    task automatic wait_frames(input int n);
        for (int i = 0; i < 3000 && frames < n; i++)
            @(posedge clk);
        if (frames < n) begin
            bad_count++;
            test_done();
        end
    endtask
    // ----------------
    // reference model of the pixel stream, compared at every handshake
    // ----------------
    always @(posedge clk) begin
        logic [31:0] ob;
        ob = back_m;                         // standby as it stood before this edge
        if (!rst && st_valid && st_ready) begin
            check(st_data, 16'((front_m + pix * 2) ^ 32'h5a5a));
            check(st_startofpacket, pix == 0);
            check(st_endofpacket, pix == PIX - 1);
            pix++;
            if (pix == PIX) begin
                pix = 0;
                frames++;
                if (pend_m) begin
                    {front_m, back_m} = {back_m, front_m};           // swap at frame end
                    pend_m = 1'b0;
                end
            end
        end
        if (avs_chipselect && avs_write && avs_address == 4'h0)
            pend_m = 1'b1;                   // a request wins over a swap in the same cycle
        if (avs_chipselect && avs_write && avs_address == 4'h4)
            for (int i = 0; i < 4; i++)
                back_m[8*i+:8] = avs_byteenable[i] ? avs_writedata[8*i+:8] : ob[8*i+:8];
    end
    // ----------------
    // main sequence
    // ----------------
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        reg_chk(4'h0, FDEF);
        reg_chk(4'h4, BDEF);
        reg_chk(4'h8, 32'h0003_0004);
        reg_chk(4'hc, 32'h0202_0022);
        reg_wr(4'h8, 32'hffff_ffff, 4'hf);
        reg_wr(4'hc, 32'hffff_00f3, 4'hf);
        reg_chk(4'h8, 32'h0003_0004);
        reg_chk(4'hc, 32'h0202_0022);
        reg_wr(4'h4, 32'h0000_3000, 4'hf);
        reg_wr(4'h4, 32'habcd_4100, 4'h3);
        reg_chk(4'h4, back_m);
        reg_wr(4'h0, 32'hdead_beef, 4'hf);
        reg_chk(4'hc, 32'h0202_0022 | pend_m);
        reg_chk(4'h0, front_m);
        go <= 1'b1;
        wait_frames(2);
        reg_chk(4'h0, front_m);
        reg_chk(4'h4, back_m);
        reg_chk(4'hc, 32'h0202_0022);
        slow <= 1'b0;
        reg_wr(4'h0, 32'h0000_0000, 4'hf);
        wait_frames(5);
        reg_chk(4'h0, front_m);
        test_done();
    end
endmodule // frame_buffer_reader_dma_test
